/* File: rtl/tlf_framer.sv */
`timescale 1ns/10ps
`include "tlf_regs.svh"
module tlf_framer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  output logic sock_req_valid_out,
  output tlf_pkg::tlf_req_t sock_req_out,
  input wire logic sock_req_ready_in,
  output logic pay_valid_out,
  output tlf_pkg::tlf_pay_t pay_out,
  input wire logic pay_ready_in,
  input wire logic sock_done_in,
  input wire logic [7:0] sock_status_in,
  output logic at_req_valid_out,
  output tlf_pkg::tlf_at_req_t at_req_out,
  input wire logic at_req_ready_in,
  input wire logic at_rsp_valid_in,
  input wire tlf_pkg::tlf_at_rsp_t at_rsp_in,
  output logic at_rsp_ready_out,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out
);
  import tlf_pkg::*;

  function automatic logic [7:0] f_at_status(input logic [7:0] s);
    f_at_status = (s > `TLF_AT_MAXST) ? `TLF_AT_ERR : s;
  endfunction

  // --------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------
  tlf_state_t st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  logic [71:0] hdr_q, hdr_d;
  logic [79:0] hdr_n;
  tlf_req_t req_q, req_d;
  tlf_at_req_t at_q, at_d;
  logic [47:0] ob_q, ob_d;
  logic [2:0] olen_q, olen_d;
  logic more_q, more_d, nopay_q, nopay_d, pv_q, pv_d;
  logic [7:0] code_q, code_d;
  tlf_pay_t pay_q, pay_d;
  logic rx_fire, tx_fire;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic ws_q, ws_d;
  logic [5:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic udp_q, udp_d;
  logic [7:0] prof_q, prof_d;
  logic [2:0] sts_q, sts_d, mask_q, mask_d, ev;
  logic [15:0] last_q, last_d, cnt_tls_q, cnt_tls_d;
  logic wfire;
  logic [7:0] last_code;
  logic last_load;

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready = !w_q && !b_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;
  assign wfire = aw_q && w_q && !b_q;
  assign irq_out = |(sts_q & mask_q);

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    r_d = r_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    rd_d = rd_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    udp_d = udp_q;
    prof_d = prof_q;
    mask_d = mask_q;
    sts_d = sts_q;
    last_d = last_load ? {req_q.id, last_code} : last_q;
    cnt_tls_d = cnt_tls_q;
    if (st_q == S_IDLE && rx_valid_in && rx_data_in == `TLF_TYPE_TLS) begin
      cnt_tls_d = cnt_tls_q + 16'h0001;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb[0];
    end
    if (wfire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = 2'h0;
      case (awa_q)
        `TLF_OFF_CTRL: if (ws_q) udp_d = wd_q[0];
        `TLF_OFF_PROF: if (ws_q) prof_d = wd_q[7:0];
        `TLF_OFF_STS: if (ws_q) sts_d = sts_q & ~wd_q[2:0];
        `TLF_OFF_MASK: if (ws_q) mask_d = wd_q[2:0];
        `TLF_OFF_LAST, `TLF_OFF_CNT: bresp_d = 2'h0;
        default: bresp_d = 2'h2;
      endcase
    end
    // set wins over clear
    sts_d = sts_d | ev;
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_d = 1'b1;
      rresp_d = 2'h0;
      case (s_axi_araddr)
        `TLF_OFF_CTRL: rd_d = {31'h0, udp_q};
        `TLF_OFF_PROF: rd_d = {24'h0, prof_q};
        `TLF_OFF_STS: rd_d = {29'h0, sts_q};
        `TLF_OFF_MASK: rd_d = {29'h0, mask_q};
        `TLF_OFF_LAST: rd_d = {16'h0, last_q};
        `TLF_OFF_CNT: rd_d = {16'h0, cnt_tls_q};
        default: begin
          rd_d = 32'h0;
          rresp_d = 2'h2;
        end
      endcase
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= 6'h0;
      wd_q <= 32'h0;
      ws_q <= 1'b0;
      rd_q <= 32'h0;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      udp_q <= `TLF_RST_CTRL;
      prof_q <= `TLF_RST_PROF;
      sts_q <= 3'h0;
      mask_q <= `TLF_RST_MASK;
      last_q <= 16'h0;
      cnt_tls_q <= 16'h0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      udp_q <= udp_d;
      prof_q <= prof_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      last_q <= last_d;
      cnt_tls_q <= cnt_tls_d;
    end
  end

  // --------------------------------------------------------------
  // framer
  // --------------------------------------------------------------

  assign hdr_n = {hdr_q, rx_data_in};
  assign rx_fire = rx_valid_in && rx_ready_out;
  assign tx_fire = tx_valid_out && tx_ready_in;
  assign tx_valid_out = st_q == S_SEND;
  assign tx_data_out = ob_q[47:40];
  assign tx_last_out = olen_q == 3'h1;
  assign sock_req_valid_out = st_q == S_REQ;
  assign sock_req_out = req_q;
  assign pay_valid_out = pv_q;
  assign pay_out = pay_q;
  assign at_req_valid_out = st_q == S_ATREQ;
  assign at_req_out = at_q;
  assign at_rsp_ready_out = st_q == S_ATWAIT;

  always_comb begin
    case (st_q)
      S_IDLE, S_ID, S_HDR, S_SKIP, S_ATH, S_DROP: rx_ready_out = 1'b1;
      S_PAY: rx_ready_out = !pv_q || pay_ready_in;
      default: rx_ready_out = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    req_d = req_q;
    at_d = at_q;
    ob_d = ob_q;
    olen_d = olen_q;
    more_d = more_q;
    nopay_d = nopay_q;
    code_d = code_q;
    pay_d = pay_q;
    pv_d = pv_q && !pay_ready_in;
    ev = 3'h0;
    last_load = 1'b0;
    last_code = code_q;
    case (st_q)
      S_IDLE: if (rx_fire && !rx_last_in) begin
        if (rx_data_in == `TLF_TYPE_TLS) st_d = S_ID; // R1
        else if (rx_data_in == `TLF_TYPE_AT) st_d = S_ATH; // R11
        else st_d = S_DROP;
        cnt_d = 11'h0;
      end
      S_ID: if (rx_fire) begin
        req_d.id = rx_data_in;
        at_d.id = rx_data_in;
        st_d = rx_last_in ? S_IDLE : (st_q == S_ID ? S_HDR : S_IDLE);
      end
      S_HDR: if (rx_fire) begin
        hdr_d = hdr_n[71:0];
        cnt_d = cnt_q + 11'h001;
        if (cnt_q == `TLF_HDR_LAST) begin
          // R2
          req_d.dst_addr = hdr_n[79:48];
          req_d.dst_port = hdr_n[47:32];
          req_d.src_port = hdr_n[31:16];
          req_d.profile = hdr_n[15:8]; // R3
          req_d.reuse_ok = hdr_n[31:16] == 16'h0; // R5 R6
          req_d.close_after = hdr_n[`TLF_OPT_CLOSE] && !udp_q; // R7 R8
          nopay_d = rx_last_in;
          cnt_d = 11'h0;
          if (hdr_n[15:8] >= prof_q) begin // R19
            code_d = `TLF_ST_BADTLS;
            st_d = rx_last_in ? S_SEND : S_SKIP;
          end else begin
            st_d = S_REQ;
          end
        end else if (rx_last_in) begin
          st_d = S_IDLE;
        end
      end
      S_REQ: if (sock_req_ready_in) st_d = nopay_q ? S_WAIT : S_PAY;
      S_PAY: if (rx_fire) begin
        pv_d = 1'b1;
        cnt_d = cnt_q + 11'h001;
        if (cnt_q == `TLF_MAX_PAY) begin // R10
          pay_d = '{data: rx_data_in, last: 1'b1, abort: 1'b1};
          code_d = `TLF_ST_TOOLONG;
          st_d = rx_last_in ? S_SEND : S_SKIP;
        end else begin
          pay_d = '{data: rx_data_in, last: rx_last_in, abort: 1'b0};
          if (rx_last_in) st_d = S_WAIT;
        end
      end
      S_SKIP: if (rx_fire && rx_last_in) st_d = S_SEND;
      S_WAIT: if (sock_done_in) begin
        code_d = sock_status_in; // R6
        st_d = S_SEND;
      end
      S_ATH: if (rx_fire) begin
        cnt_d = cnt_q + 11'h001;
        case (cnt_q)
          11'h000: at_d.id = rx_data_in;
          11'h001: at_d.cmd[15:8] = rx_data_in;
          11'h002: begin
            at_d.cmd[7:0] = rx_data_in;
            at_d.has_param = 1'b0;
          end
          11'h003: begin
            at_d.param = rx_data_in;
            at_d.has_param = 1'b1;
          end
          default: cnt_d = cnt_q;
        endcase
        if (rx_last_in) st_d = cnt_q >= 11'h002 ? S_ATREQ : S_IDLE;
      end
      S_ATREQ: if (at_req_ready_in) st_d = S_ATWAIT;
      S_ATWAIT: if (at_rsp_valid_in) begin
        ev[1] = 1'b1;
        more_d = !at_rsp_in.final_rsp; // R12
        if (at_q.id != 8'h0) begin // R13
          // R14 R15 R16
          ob_d = {`TLF_TYPE_ATR, at_q.id, at_q.cmd,
                  f_at_status(at_rsp_in.status), at_rsp_in.param};
          olen_d = at_rsp_in.has_param ? 3'h6 : 3'h5;
          st_d = S_SEND;
        end else if (at_rsp_in.final_rsp) begin
          st_d = S_IDLE;
        end
      end
      S_SEND: if (tx_fire) begin
        ob_d = {ob_q[39:0], 8'h0};
        olen_d = olen_q - 3'h1;
        if (olen_q == 3'h1) st_d = more_q ? S_ATWAIT : S_IDLE;
      end
      S_DROP: if (rx_fire && rx_last_in) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    // tls outcome: load status frame or drop it for id zero
    if (st_d == S_SEND && st_q != S_SEND && st_q != S_ATWAIT) begin
      ev[0] = 1'b1;
      ev[2] = code_d != `TLF_ST_OK;
      last_load = 1'b1;
      last_code = code_d;
      more_d = 1'b0;
      ob_d = {`TLF_TYPE_TXS, req_q.id, code_d, 24'h0}; // R18 R4
      olen_d = 3'h3;
      if (req_q.id == 8'h0) st_d = S_IDLE; // R4
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q <= S_IDLE;
      cnt_q <= 11'h0;
      hdr_q <= 72'h0;
      req_q <= '0;
      at_q <= '0;
      ob_q <= 48'h0;
      olen_q <= 3'h0;
      more_q <= 1'b0;
      nopay_q <= 1'b0;
      code_q <= 8'h0;
      pay_q <= '0;
      pv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      req_q <= req_d;
      at_q <= at_d;
      ob_q <= ob_d;
      olen_q <= olen_d;
      more_q <= more_d;
      nopay_q <= nopay_d;
      code_q <= code_d;
      pay_q <= pay_d;
      pv_q <= pv_d;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_tls_type;
    @(posedge clock_in) disable iff (rst_in)
    st_q == S_IDLE && rx_fire && !rx_last_in && rx_data_in == 8'h23 |=> st_q == S_ID;
  endproperty
  a_tls_type: assert property (p_tls_type) else $error("tls type missed"); // R1
  property p_udp;
    @(posedge clock_in) disable iff (rst_in)
    sock_req_valid_out && udp_q |-> !sock_req_out.close_after;
  endproperty
  a_udp: assert property (p_udp) else $error("close set for udp"); // R8
  property p_reuse;
    @(posedge clock_in) disable iff (rst_in)
    sock_req_valid_out |-> sock_req_out.reuse_ok == (sock_req_out.src_port == 16'h0);
  endproperty
  a_reuse: assert property (p_reuse) else $error("reuse flag wrong"); // R5
  property p_prof;
    @(posedge clock_in) disable iff (rst_in)
    sock_req_valid_out |-> sock_req_out.profile < prof_q;
  endproperty
  a_prof: assert property (p_prof) else $error("bad profile issued"); // R19
  property p_pay_max;
    @(posedge clock_in) disable iff (rst_in)
    pay_valid_out && !pay_out.abort |-> cnt_q <= 11'h5dc;
  endproperty
  a_pay_max: assert property (p_pay_max) else $error("payload too long"); // R10
  property p_id0;
    @(posedge clock_in) disable iff (rst_in)
    st_q == S_WAIT && sock_done_in && req_q.id == 8'h0 |=> st_q == S_IDLE;
  endproperty
  a_id0: assert property (p_id0) else $error("status sent for id 0"); // R4
  property p_txs;
    @(posedge clock_in) disable iff (rst_in)
    st_q == S_WAIT && sock_done_in && req_q.id != 8'h0 |=>
      st_q == S_SEND && ob_q[47:24] == {8'h89, req_q.id, $past(sock_status_in)};
  endproperty
  a_txs: assert property (p_txs) else $error("bad tx status frame"); // R18
  property p_atr;
    @(posedge clock_in) disable iff (rst_in)
    at_rsp_valid_in && at_rsp_ready_out && at_q.id != 8'h0 |=>
      ob_q[47:16] == {8'h88, at_q.id, at_q.cmd} && ob_q[15:8] <= 8'h03 &&
      olen_q == ($past(at_rsp_in.has_param) ? 3'h6 : 3'h5);
  endproperty
  a_atr: assert property (p_atr) else $error("bad at response"); // R13
  property p_sticky;
    @(posedge clock_in) disable iff (rst_in)
    !wfire |=> (sts_q & $past(sts_q)) == $past(sts_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");
endmodule

/* File: rtl/tlf_regs.svh */
// What the document requires
// [R1] frame type 0x23 is a TLS transmit request
// [R2] body order: type,id,addr,dport,sport,profile,options,payload
// [R3] profile byte is zero-based TLS profile index
// [R4] echo id in status; id 0 suppresses it
// [R5] source port zero: reuse match or open new
// [R6] nonzero source port: exact match or error
// [R7] option bit 1 set closes TCP socket after send
// [R8] option bit 1 ignored for UDP
// [R9] host keeps reserved option bits zero
// [R10] payload at most 1500 bytes
// [R11] AT command 0x08 answered by frame 0x88
// [R12] host accepts several responses per command
// [R13] echo id in response; id 0 sends none
// [R14] response carries two-character command name
// [R15] status codes: 0 ok, 1 error, 2, 3
// [R16] parameter only on query, omitted on set
// [R17] host pairs responses by echoed id
// [R18] transmit status frame 0x89, id, status
// [R19] out-of-range profile fails via transmit status
`ifndef TLF_REGS_SVH
`define TLF_REGS_SVH
`define TLF_TYPE_TLS 8'h23
`define TLF_TYPE_AT 8'h08
`define TLF_TYPE_ATR 8'h88
`define TLF_TYPE_TXS 8'h89
`define TLF_ST_OK 8'h00
`define TLF_ST_TOOLONG 8'h74
`define TLF_ST_BADTLS 8'h86
`define TLF_AT_ERR 8'h01
`define TLF_AT_MAXST 8'h03
`define TLF_MAX_PAY 11'h5dc
`define TLF_HDR_LAST 11'h009
`define TLF_OPT_CLOSE 1
`define TLF_OFF_CTRL 6'h00
`define TLF_OFF_PROF 6'h04
`define TLF_OFF_STS 6'h08
`define TLF_OFF_MASK 6'h0c
`define TLF_OFF_LAST 6'h10
`define TLF_OFF_CNT 6'h14
`define TLF_RST_CTRL 1'h0
`define TLF_RST_PROF 8'h03
`define TLF_RST_MASK 3'h0
`endif

/* File: rtl/tlf_pkg.sv */
package tlf_pkg;
  typedef struct packed {
    logic [7:0] id;
    logic [31:0] dst_addr;
    logic [15:0] dst_port;
    logic [15:0] src_port;
    logic [7:0] profile;
    logic reuse_ok;
    logic close_after;
  } tlf_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic abort;
  } tlf_pay_t;
  typedef struct packed {
    logic [7:0] id;
    logic [15:0] cmd;
    logic [7:0] param;
    logic has_param;
  } tlf_at_req_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] param;
    logic has_param;
    logic final_rsp;
  } tlf_at_rsp_t;
  typedef enum logic [3:0] {
    S_IDLE, S_ID, S_HDR, S_REQ, S_PAY, S_SKIP, S_WAIT, S_SEND,
    S_ATH, S_ATREQ, S_ATWAIT, S_DROP
  } tlf_state_t;
endpackage

/* File: test/tlf_host_model.sv */
`timescale 1ns/10ps
module tlf_host_model (
  input wire logic clock_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  logic [8:0] got[$];
  logic slow;
  logic [1:0] ph = 2'h0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_last_out = 1'b0;
    slow = 1'b0;
  end
  // ----
  // frame sender, bytes in caller order
  // ----
  task automatic send(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= f[i];
      rx_last_out <= (i == f.size() - 1);
      do @(posedge clock_in); while (rx_ready_in !== 1'b1);
    end
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~f[f.size() - 1];
    @(posedge clock_in);
  endtask
  // ----
  // response sink, stalls when slow
  // ----
  always @(posedge clock_in) begin
    ph <= ph + 2'h1;
    tx_ready_out <= !slow || ph[0];
    if (tx_valid_in && tx_ready_out) begin
      got.push_back({tx_last_in, tx_data_in});
    end
  end
endmodule

/* File: test/tlf_framer_tb.sv */
`timescale 1ns/10ps
module tlf_framer_tb;
  import tlf_pkg::*;
  logic clock_in, rst_in, rx_valid_in, rx_last_in, rx_ready_out, tx_valid_out;
  logic tx_last_out, tx_ready_in, sock_req_valid_out, sock_req_ready_in, pay_valid_out;
  logic pay_ready_in, sock_done_in, at_req_valid_out, at_req_ready_in, at_rsp_valid_in;
  logic at_rsp_ready_out, irq_out;
  logic [7:0] rx_data_in, tx_data_out, sock_status_in;
  tlf_req_t sock_req_out;
  tlf_pay_t pay_out;
  tlf_at_req_t at_req_out;
  tlf_at_rsp_t at_rsp_in;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, seed, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int error_cnt, compares, cyc, tn;
  tlf_req_t rq[$];
  tlf_pay_t pq[$];
  tlf_at_req_t aq[$];
  logic [8:0] ex[$];
  tlf_framer u_dut (.*);
  tlf_host_model u_host (
    .clock_in, .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .rx_last_out(rx_last_in), .rx_ready_in(rx_ready_out), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in)
  );
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [95:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ef(input logic [7:0] b[$]);
    foreach (b[i]) ex.push_back({i == b.size() - 1, b[i]});
  endtask
  task automatic cmp_tx();
    for (int k = 0; k < 400 && u_host.got.size() < ex.size(); k++) @(posedge clock_in);
    repeat (20) @(posedge clock_in);
    chk(u_host.got.size(), ex.size());
    foreach (ex[i]) chk(u_host.got[i], ex[i]);
    u_host.got.delete();
    ex.delete();
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic axi_rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock_in);
  endtask
  // ----
  // tls request and its expected outcome
  // ----
  task automatic tls(input logic [7:0] id, pr, op, input logic [15:0] sp, input int n,
                     input logic [7:0] st, input logic udp);
    logic [31:0] a;
    logic [31:0] r;
    logic [7:0] f[$];
    logic [7:0] p[$];
    logic [7:0] s;
    tlf_req_t e;
    int m;
    a = xs();
    f = {8'h23, id, a[31:24], a[23:16], a[15:8], a[7:0], a[23:16], a[15:8]};
    f = {f, sp[15:8], sp[7:0], pr, op};
    for (int i = 0; i < n; i++) begin
      r = xs();
      p.push_back(r[7:0]);
    end
    e = '{id, a, a[23:8], sp, pr, sp == 16'h0000, op[1] & !udp};
    s = (pr >= 8'h03) ? 8'h86 : (n > 1500) ? 8'h74 : st;
    u_host.send({f, p});
    if (pr < 8'h03) begin
      m = (n > 1500) ? 1501 : n;
      for (int k = 0; k < 9000 && (rq.size() == 0 || pq.size() < m); k++) begin
        @(posedge clock_in);
      end
      chk(rq.size(), 1);
      chk(rq.pop_front(), e);
      chk(pq.size(), m);
      for (int i = 0; i < m; i++) chk(pq[i], {p[i], i == m - 1, i == 1500});
      pq.delete();
      if (n <= 1500) begin
        repeat (2) @(posedge clock_in);
        sock_done_in <= 1'b1;
        sock_status_in <= st;
        @(posedge clock_in);
        sock_done_in <= 1'b0;
        sock_status_in <= ~st;
      end
    end
    if (id != 8'h00) ef({8'h89, id, s});
    cmp_tx();
    chk(rq.size() + pq.size(), 0);
  endtask
  // ----
  // at command with five replies
  // ----
  task automatic at(input logic [7:0] id, c1, c2, input logic hp);
    logic [7:0] f[$];
    logic [7:0] q[$];
    tlf_at_req_t a;
    f = {8'h08, id, c1, c2};
    if (hp) f.push_back(8'h10);
    u_host.send(f);
    for (int k = 0; k < 500 && aq.size() == 0; k++) @(posedge clock_in);
    chk(aq.size(), 1);
    a = aq.pop_front();
    chk({a.id, a.cmd, a.has_param, hp ? a.param : 8'h10}, {id, c1, c2, hp, 8'h10});
    for (int s = 0; s < 5; s++) begin
      at_rsp_in <= '{s == 4 ? 8'h05 : 8'(s), 8'h40 + 8'(s), s < 2, s == 4};
      at_rsp_valid_in <= 1'b1;
      do @(posedge clock_in); while (at_rsp_ready_out !== 1'b1);
      q = {8'h88, id, c1, c2, s == 4 ? 8'h01 : 8'(s)};
      if (s < 2) q.push_back(8'h40 + 8'(s));
      if (id != 8'h00) ef(q);
    end
    at_rsp_valid_in <= 1'b0;
    at_rsp_in <= 18'h2a5a5;
    cmp_tx();
  endtask
  // ----
  // far-side engines and timeout
  // ----
  always @(posedge clock_in) begin
    rnd = xs();
    sock_req_ready_in <= rnd[0];
    pay_ready_in <= rnd[1] | rnd[2];
    at_req_ready_in <= rnd[3];
    if (sock_req_valid_out && sock_req_ready_in) rq.push_back(sock_req_out);
    if (pay_valid_out && pay_ready_in) pq.push_back(pay_out);
    if (at_req_valid_out && at_req_ready_in) aq.push_back(at_req_out);
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // ----
  // main sequence
  // ----
  initial begin
    seed = 32'd25;
    rst_in = 1'b1;
    sock_done_in = 1'b0;
    {at_rsp_valid_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 14'h0;
    sock_status_in = 8'h00;
    at_rsp_in = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    chk({irq_out, rx_ready_out, tx_valid_out}, 3'h2);
    for (int i = 0; i < 7; i++) begin
      axi_rd(6'(4 * i));
      chk({rrsp, rdat}, {i == 6 ? 2'h2 : 2'h0, i == 1 ? 32'h3 : 32'h0});
    end
    axi_wr(6'h18, 32'h1);
    chk(brsp, 2'h2);
    cmp_tx();
    axi_wr(6'h0c, 32'h1);
    chk(brsp, 2'h0);
    u_host.slow = 1'b1;
    tls(8'h05, 8'h00, 8'h02, 16'h0000, 3, 8'h00, 1'b0);
    chk(irq_out, 1'b1);
    axi_rd(6'h10);
    chk(rdat[15:0], 16'h0500);
    axi_wr(6'h08, 32'h7);
    chk(irq_out, 1'b0);
    u_host.slow = 1'b0;
    axi_wr(6'h00, 32'h1);
    tls(8'h00, 8'h02, 8'h02, 16'h1234, 1, 8'h83, 1'b1);
    axi_wr(6'h00, 32'h0);
    tls(8'h09, 8'h03, 8'h00, 16'h0000, 2, 8'h00, 1'b0);
    tls(8'h0a, 8'h01, 8'h02, 16'h0000, 1502, 8'h00, 1'b0);
    axi_rd(6'h14);
    chk(rdat, 32'h4);
    at(8'h07, 8'h4e, 8'h49, 1'b0);
    at(8'h00, 8'h44, 8'h4c, 1'b1);
    wrap_up();
  end
endmodule
